// *** inc/sdl_pkg.sv ***
// Package with constants and types for the serial converter load interface.
package sdl_pkg;
    localparam int SDL_WORD_W = 12;
    localparam logic [11:0] SDL_WORD_RST = 12'h000;
    localparam int SDL_SYNC_STAGES = 2;
    localparam logic [1:0] SDL_SYNC_RST = 2'h0;
    localparam logic [3:0] SDL_CNT_RST = 4'h0;
    localparam logic [3:0] SDL_CNT_MAX = 4'hc;
    typedef logic [SDL_WORD_W-1:0] sdl_word_t;
endpackage

// *** verification/sdl_host.sv ***
// Host model that shifts words in and strobes the load.
`timescale 1ns/1ps
module sdl_host (
    output logic sclk = 1'b0,
    output logic sdi = 1'b0,
    output logic ld_n = 1'b1
);
    task automatic send(input logic [15:0] w, input int n, input bit ld);
        for (int i = n - 1; i >= 0; i--) begin
            sdi = w[i];
            #62.5 sclk = 1'b1;
            // The line stops holding the bit partway through the high phase.
            #31.25 sdi = ~w[i];
            #31.25 sclk = 1'b0;
        end
        #400;
        if (ld) begin
            ld_n = 1'b0;
            #500 ld_n = 1'b1;
        end
        #300;
    endtask
endmodule

// *** verification/serial_dac_load_interface_bench.sv ***
// Bench for the serial load interface driven by the host model.
`timescale 1ns/1ps
module serial_dac_load_interface_bench;
    import sdl_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic sclk;
    logic sdi;
    logic ld_n;
    sdl_word_t conv_word;
    logic [3:0] bits_shifted;
    int fail_count = 0;
    int check_count = 0;
    always #50 mclk = ~mclk;
    sdl_load_if dut (.mclk(mclk), .rst_n(rst_n), .serial_clk(sclk), .serial_data_in(sdi),
        .load_strobe_n(ld_n), .conv_word(conv_word), .bits_shifted(bits_shifted));
    sdl_host host (.sclk(sclk), .sdi(sdi), .ld_n(ld_n));
    task automatic chk(input string nm, input sdl_word_t seen, input sdl_word_t exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        if (fail_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge mclk);
        #5 rst_n = 1'b1;
        repeat (3) @(posedge mclk);
        #5;
        chk("reset", conv_word, SDL_WORD_RST);
        host.send(16'h0a5c, 12, 1'b1);
        chk("word", conv_word, 12'ha5c);
        chk("bits after load", {8'h00, bits_shifted}, 12'h000);
        host.send(16'hf3c1, 16, 1'b1);
        chk("extra", conv_word, 12'h3c1);
        host.send(16'h0777, 12, 1'b0);
        chk("hold", conv_word, 12'h3c1);
        chk("bits no load", {8'h00, bits_shifted}, {8'h00, SDL_CNT_MAX});
        conclude();
    end
endmodule

// *** verilog/sdl_load_if.sv ***
// Serial shift register and level-sensitive load into the converter register.
// Operation
// - Each serial clock rising edge shifts data in.
// - Twelve-bit register, most significant bit first.
// - Only the last twelve bits are kept.
// - Low load strobe copies shift register continuously.
`timescale 1ns/1ps
module sdl_load_if
    import sdl_pkg::*;
#(
    parameter int WORD_W = SDL_WORD_W
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic serial_clk,
    input wire logic serial_data_in,
    input wire logic load_strobe_n,
    output sdl_pkg::sdl_word_t conv_word,
    output logic [3:0] bits_shifted
);
    import sdl_pkg::*;


    // Width of the free-running count of serial edges behind bits_shifted. 256 or more
    // edges between two loads wrap the count, so the status can then read short.
    localparam int EDGE_W = 8;

    // The serial clock owns the shift register. It has no reset, just as the pin logic
    // has none, so it holds whatever was last shifted in.
    sdl_word_t shift_q = SDL_WORD_RST;

    always_ff @(posedge serial_clk) begin
        shift_q <= {shift_q[WORD_W-2:0], serial_data_in};
    end

    // Every serial edge is counted in the link domain. Only the Gray copy crosses, so a
    // sample caught during an update is off by one edge at most and never torn.
    logic [EDGE_W-1:0] edge_bin_q = '0;
    logic [EDGE_W-1:0] edge_gray_q = '0;
    logic [EDGE_W-1:0] edge_bin_d;

    always_comb begin
        edge_bin_d = edge_bin_q + EDGE_W'(1);
    end

    always_ff @(posedge serial_clk) begin
        edge_bin_q <= edge_bin_d;
    end

    always_ff @(posedge serial_clk) begin
        edge_gray_q <= edge_bin_d ^ (edge_bin_d >> 1);
    end

    // The shift register word crosses as a plain bundle. That is safe only because the
    // host keeps the serial clock idle around a load, which it must do anyway for the
    // word to be complete; a clock running during the strobe can pass a mixed word.
    sdl_word_t word_sync;
    logic [EDGE_W-1:0] gray_sync;
    logic load_n_sync;

    sdl_sync #(.W(WORD_W)) u_word_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .din(shift_q),
        .dout(word_sync)
    );

    sdl_sync #(.W(EDGE_W)) u_edge_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .din(edge_gray_q),
        .dout(gray_sync)
    );

    sdl_sync #(.W(1)) u_load_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .din(load_strobe_n),
        .dout(load_n_sync)
    );

    // The strobe synchroniser resets to zero, which would read as a load strobe. A short
    // settle register masks the strobe until real pin samples have come through, so a
    // reset in mid-run cannot copy a half-shifted word into the converter register.
    logic [SDL_SYNC_STAGES-1:0] settle_q;
    logic load_act;
    logic load_act_d1_q;
    logic load_start;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            settle_q <= SDL_SYNC_RST;
        end else begin
            settle_q <= {settle_q[SDL_SYNC_STAGES-2:0], 1'b1};
        end
    end

    always_comb begin
        load_act = settle_q[SDL_SYNC_STAGES-1] && !load_n_sync;
        load_start = load_act && !load_act_d1_q;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            load_act_d1_q <= 1'b0;
        end else begin
            load_act_d1_q <= load_act;
        end
    end

    // The strobe is a level, not an edge: the register follows the shift register for
    // as long as the strobe stays low, and the last word seen is the one kept.
    sdl_word_t conv_q;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            conv_q <= SDL_WORD_RST;
        end else if (load_act) begin
            conv_q <= word_sync;
        end
        // Otherwise the register keeps the last loaded word.
    end

    // Gray back to binary, most significant bit first.
    logic [EDGE_W-1:0] edge_now;

    always_comb begin
        edge_now[EDGE_W-1] = gray_sync[EDGE_W-1];
        for (int i = EDGE_W - 2; i >= 0; i--) begin
            edge_now[i] = edge_now[i+1] ^ gray_sync[i];
        end
    end

    // The edge count is marked when a load starts; the status is the distance from that
    // mark, capped at one word. After a reset in mid-run the first reading may be off,
    // since the link-domain count itself has no reset.
    logic [EDGE_W-1:0] mark_q;
    logic [EDGE_W-1:0] since_load;
    logic [3:0] bits_q;

    always_comb begin
        since_load = edge_now - mark_q;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mark_q <= '0;
        end else if (load_start) begin
            mark_q <= edge_now;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bits_q <= SDL_CNT_RST;
        end else if (since_load >= EDGE_W'(SDL_CNT_MAX)) begin
            bits_q <= SDL_CNT_MAX;
        end else begin
            bits_q <= since_load[3:0];
        end
    end

    assign conv_word = conv_q;
    assign bits_shifted = bits_q;

    // Checks on the system clock side.
    a_load_copies: assert property (@(posedge mclk) disable iff (!rst_n)
        load_act |=> conv_q == $past(word_sync))
        else $error("converter register did not follow shift register");

    a_hold_high: assert property (@(posedge mclk) disable iff (!rst_n)
        !load_act |=> $stable(conv_q))
        else $error("converter register changed with load high");

    a_reset_word: assert property (@(posedge mclk)
        !rst_n |=> conv_q == SDL_WORD_RST)
        else $error("converter register not cleared by reset");

    a_settle_mask: assert property (@(posedge mclk) disable iff (!rst_n)
        !settle_q[SDL_SYNC_STAGES-1] |-> !load_act)
        else $error("load taken before strobe synchroniser settled");

    a_start_once: assert property (@(posedge mclk) disable iff (!rst_n)
        load_start |=> !load_start)
        else $error("load start lasted more than one cycle");

    a_mark_load: assert property (@(posedge mclk) disable iff (!rst_n)
        load_start |=> mark_q == $past(edge_now))
        else $error("edge mark not taken at load start");

    a_bits_limit: assert property (@(posedge mclk) disable iff (!rst_n)
        bits_q <= SDL_CNT_MAX)
        else $error("bit count above one word");

    a_bits_follow: assert property (@(posedge mclk) disable iff (!rst_n)
        since_load < EDGE_W'(SDL_CNT_MAX) |=> bits_q == $past(since_load[3:0]))
        else $error("bit count does not follow edges since load");

    // Checks on the serial clock side.
    a_shift_in: assert property (@(posedge serial_clk)
        shift_q[0] == $past(serial_data_in))
        else $error("serial bit not shifted in");

    a_keep_last: assert property (@(posedge serial_clk)
        shift_q[WORD_W-1:1] == $past(shift_q[WORD_W-2:0]))
        else $error("shift register lost order");

    a_gray_match: assert property (@(posedge serial_clk)
        edge_gray_q == (edge_bin_q ^ (edge_bin_q >> 1)))
        else $error("edge count copies disagree");
endmodule

// *** verilog/sdl_sync.sv ***
// Two flip-flop synchroniser for a bundle of levels.
`timescale 1ns/1ps
module sdl_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule
